//--- bench/save_mem.sv
// Purpose: Save-area memory on the far side of the save engine
// Assumes: Held request, one write taken per one-cycle ack
// Notes:   slow inserts three wait cycles before every ack
`timescale 1ns/10ps
module save_mem (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire sss_pkg::mem_req_t mem_i,
  input  wire logic              slow,
  output logic                   mem_ack
);
  import sss_pkg::*;
  logic [63:0] mem [logic [31:0]];
  int          wcnt = 0;
  int          wt;
  // Write lands only at the edge that sees req and ack together
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ack <= 1'b0;
      wt = 0;
    end else if (mem_i.req && mem_ack) begin
      mem[mem_i.addr] = mem_i.wdata;
      wcnt++;
      mem_ack <= 1'b0;
    end else if (mem_i.req) begin
      if (wt >= (slow ? 3 : 0)) begin
        mem_ack <= 1'b1;
        wt = 0;
      end else begin
        wt++;
      end
    end
  end
endmodule

//--- bench/supervisor_state_save_tb.sv
// Purpose: Self-checking bench for the supervisor save engine
// Assumes: Zero-wait APB slave, component data from comp_sel
// Notes:   Memory contents are read back from the partner model
`timescale 1ns/10ps
module supervisor_state_save_tb;
  import sss_pkg::*;
  logic        pclk = 0;
  logic        presetn = 0;
  logic        psel = 0;
  logic        penable = 0;
  logic        pwrite = 0;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  mem_req_t    mem_o;
  logic        mem_ack;
  logic [5:0]  comp_sel;
  logic [63:0] comp_data;
  logic        slow = 0;
  logic [31:0] rd;
  logic        er;
  int          mismatches = 0;
  int          checks = 0;
  int          cyc = 0;
  logic [31:0] fc [5] = '{32'h0, 32'h9, 32'h101, 32'h1, 32'h331};
  logic [31:0] fa [5] = '{32'h1000, 32'h1000, 32'h1000, 32'h1010, 32'h1010};
  logic [2:0]  ff [5] = '{3'h1, 3'h2, 3'h3, 3'h3, 3'h4};
  ////////////////////////////////////////////////////////////////////
  assign comp_data = {32'hc0de_0000, 26'h0, comp_sel};
  always #4 pclk = ~pclk;
  supervisor_state_save u_supervisor_state_save (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mem_o(mem_o),
    .mem_ack(mem_ack), .comp_sel(comp_sel), .comp_data(comp_data));
  save_mem u_save_mem (.pclk(pclk), .presetn(presetn), .mem_i(mem_o),
    .slow(slow), .mem_ack(mem_ack));
  ////////////////////////////////////////////////////////////////////
  function automatic logic [63:0] cd(input logic [5:0] i);
    return {32'hc0de_0000, 26'h0, i};
  endfunction
  task automatic close_out();
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk({er, rd}, {1'b0, e});
  endtask
  task automatic mck(input logic [31:0] a, input logic [63:0] e);
    chk(u_save_mem.mem[a], e);
  endtask
  // Start a save, wait for busy to drop, check fault and write count
  task automatic save(input logic [2:0] f, input int nw);
    int b;
    b = u_save_mem.wcnt;
    wr(8'h34, 32'h1);
    do apb(1'b0, 8'h38, 32'h0); while (rd[3] !== 1'b0);
    chk(rd[2:0], f);
    chk(64'(u_save_mem.wcnt - b), 64'(nw));
  endtask
  ////////////////////////////////////////////////////////////////////
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      close_out();
    end
  end
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rdc(8'h00, 32'h1);
    rdc(8'h14, 32'h1f80);
    apb(1'b0, 8'h4c, 32'h0);
    chk({er, rd}, {1'b1, 32'h0});
    wr(8'h00, 32'h4);
    rdc(8'h38, 32'h5);
    rdc(8'h00, 32'h1);
    wr(8'h00, 32'h7);
    wr(8'h08, 32'h10);
    wr(8'h28, 32'h17);
    wr(8'h18, 32'h15);
    wr(8'h14, 32'h1f81);
    for (int i = 0; i < 5; i++) begin
      wr(8'h10, fc[i]);
      wr(8'h30, fa[i]);
      save(ff[i], 0);
    end
    wr(8'h10, 32'h1);
    wr(8'h30, 32'h1000);
    slow <= 1'b1;
    save(3'h0, 6);
    mck(32'h1200, 64'h17);
    mck(32'h1208, 64'h8000_0000_0000_0017);
    mck(32'h1008, cd(6'h1));
    mck(32'h1240, cd(6'h2));
    mck(32'h1248, cd(6'h4));
    slow <= 1'b0;
    wr(8'h14, 32'h1f80);
    wr(8'h18, 32'h11);
    wr(8'h30, 32'h2000);
    save(3'h0, 4);
    mck(32'h2200, 64'h11);
    mck(32'h2000, cd(6'h0));
    mck(32'h2248, cd(6'h4));
    wr(8'h18, 32'h15);
    wr(8'h20, 32'h1);
    wr(8'h30, 32'h3000);
    wr(8'h34, 32'h2);
    rdc(8'h3c, 32'h17);
    rdc(8'h40, 32'h8000_0000);
    rdc(8'h44, 32'h3000);
    rdc(8'h48, 32'h0);
    save(3'h0, 3);
    mck(32'h3000, cd(6'h0));
    wr(8'h34, 32'h4);
    rdc(8'h40, 32'h0);
    save(3'h0, 5);
    wr(8'h10, 32'h1001);
    wr(8'h34, 32'h2);
    rdc(8'h48, 32'h8);
    wr(8'h10, 32'h1);
    save(3'h0, 5);
    wr(8'h10, 32'h1001);
    save(3'h0, 3);
    close_out();
  end
endmodule

//--- rtl/sss_defines.svh
// Purpose: Offsets, field positions, reset values for the state-save block
// Assumes: Byte addresses on a 32-bit APB, one word per register
// Notes:   Save-area layout counts one 64-bit word per state component
`ifndef SSS_DEFINES_SVH
`define SSS_DEFINES_SVH
`define OFF_UCE_LO    8'h00
`define OFF_UCE_HI    8'h04
`define OFF_SCE_LO    8'h08
`define OFF_SCE_HI    8'h0c
`define OFF_CTRL      8'h10
`define OFF_SIMD      8'h14
`define OFF_INUSE_LO  8'h18
`define OFF_INUSE_HI  8'h1c
`define OFF_MOD_LO    8'h20
`define OFF_MOD_HI    8'h24
`define OFF_MASK_LO   8'h28
`define OFF_MASK_HI   8'h2c
`define OFF_ADDR      8'h30
`define OFF_CMD       8'h34
`define OFF_STAT      8'h38
`define OFF_TBM_LO    8'h3c
`define OFF_TBM_HI    8'h40
`define OFF_TADDR     8'h44
`define OFF_TMISC     8'h48
`define CTRL_OSX      0
`define CTRL_TS       3
`define CTRL_AM       4
`define CTRL_ACF      5
`define CTRL_PRIV_LO  8
`define CTRL_NR       12
`define CMD_SAVE      0
`define CMD_REC_SUP   1
`define CMD_REC_STD   2
`define RST_UCE       64'h0000_0000_0000_0001
`define RST_SIMD      32'h0000_1f80
`define HDR_STATE_OFF 32'h0000_0200
`define HDR_COMP_OFF  32'h0000_0208
`define EXT_OFF       32'h0000_0240
`define LAST_COMP     6'h3e
`endif

//--- rtl/sss_pkg.sv
// Purpose: Types shared by the state-save block
// Assumes: Nothing beyond the defines header
// Notes:   Fault codes are reported in the status register
package sss_pkg;
  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_HDRS = 4'b0010,
    S_HDRC = 4'b0100,
    S_COMP = 4'b1000
  } state_t;
  typedef enum logic [2:0] {
    F_NONE   = 3'h0,
    F_BAD_OP = 3'h1,
    F_NO_DEV = 3'h2,
    F_PROT   = 3'h3,
    F_ALIGN  = 3'h4,
    F_XCW    = 3'h5
  } fault_t;
  typedef struct packed {
    logic        req;
    logic [31:0] addr;
    logic [63:0] wdata;
  } mem_req_t;
endpackage

//--- rtl/supervisor_state_save.sv
// Purpose: Supervisor compacted save engine behind an APB register file
// Assumes: Save memory takes a held request and returns a one-cycle ack
// Notes:   Configuration writes are ignored while a save is running
//
// Summary of operation
// - Save only at privilege level zero
// - Requested bitmap is mask AND enables OR
// - Save feature off raises invalid opcode
// - Task-switched flag raises device not available
// - Misaligned save area raises general protection
// - Alignment check may replace protection fault
// - Unrequested header state bits write zero
// - Requested header bits copy in-use indicator
// - Dirty SIMD status forces component one
// - Compaction bitmap gets bit 63 plus bitmap
// - Legacy then compacted extended region layout
// - Init optimization skips unused components
// - Modified optimization needs full tuple match
// - Unmodified components skipped under optimization
// - Restores record the four-part tuple
// - Extended control write rejects bit2 without bit1
// - Memory operand plus 64-bit instruction mask
//
// The placing of the registers and the APB register port are this design's own decisions.
`timescale 1ns/10ps
`include "sss_defines.svh"
module supervisor_state_save (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  output sss_pkg::mem_req_t      mem_o,
  input  wire logic              mem_ack,
  output logic [5:0]             comp_sel,
  input  wire logic [63:0]       comp_data
);
  import sss_pkg::*;

  typedef struct packed {
    state_t      st;
    logic [63:0] uce;
    logic [63:0] sce;
    logic [31:0] ctrl;
    logic [31:0] simd;
    logic [63:0] inuse;
    logic [63:0] modif;
    logic [63:0] mask;
    logic [31:0] addr;
    logic [63:0] tbm;
    logic [31:0] taddr;
    logic [1:0]  tcpl;
    logic        tnr;
    logic [5:0]  idx;
    logic [5:0]  ext;
    fault_t      fault;
    logic        done;
    mem_req_t    mem;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } regs_t;

  regs_t       r;
  regs_t       n;
  logic [63:0] requested_bitmap;
  logic [63:0] state_bitmap;
  logic        mxd;
  logic        modopt;
  logic        store;
  logic        adv;
  logic        wr;
  logic        busy;
  logic [1:0]  current_privilege_level;
  logic        mis;

  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = (a[1:0] == 2'b00) && (a <= `OFF_TMISC);
  endfunction

  // Legacy components take fixed words, extended ones pack by bitmap
  function automatic logic [31:0] comp_addr(input logic [31:0] base,
                                            input logic [5:0]  i,
                                            input logic [5:0]  e);
    if (i < 6'h02)
      comp_addr = base + {23'h0, i, 3'h0};
    else
      comp_addr = base + `EXT_OFF + {23'h0, e, 3'h0};
  endfunction

  assign current_privilege_level = r.ctrl[`CTRL_PRIV_LO +: 2];
  assign mis  = (r.addr[5:0] != 6'h00);
  assign busy = (r.st != S_IDLE);
  assign wr   = psel & penable & r.pready & pwrite;
  assign requested_bitmap = r.mask & (r.uce | r.sce);
  assign mxd  = (r.simd != `RST_SIMD);
  assign state_bitmap = requested_bitmap &
                        (r.inuse | {62'h0, mxd, 1'b0});
  assign modopt = (r.tcpl == current_privilege_level) &&
                  (r.tnr == r.ctrl[`CTRL_NR]) &&
                  (r.taddr == r.addr) && r.tbm[63] &&
                  (r.tbm[62:0] == requested_bitmap[62:0]);
  assign store = state_bitmap[r.idx] & (~modopt | r.modif[r.idx]);

  always_comb begin
    n = r;
    adv = 1'b0;
    n.pready = psel & ~penable & ~r.pready;
    n.pslverr = psel & ~penable & ~addr_hit(paddr);
    if (psel & ~penable) begin
      unique case (paddr)
        `OFF_UCE_LO:   n.prdata = r.uce[31:0];
        `OFF_UCE_HI:   n.prdata = r.uce[63:32];
        `OFF_SCE_LO:   n.prdata = r.sce[31:0];
        `OFF_SCE_HI:   n.prdata = r.sce[63:32];
        `OFF_CTRL:     n.prdata = r.ctrl;
        `OFF_SIMD:     n.prdata = r.simd;
        `OFF_INUSE_LO: n.prdata = r.inuse[31:0];
        `OFF_INUSE_HI: n.prdata = r.inuse[63:32];
        `OFF_MOD_LO:   n.prdata = r.modif[31:0];
        `OFF_MOD_HI:   n.prdata = r.modif[63:32];
        `OFF_MASK_LO:  n.prdata = r.mask[31:0];
        `OFF_MASK_HI:  n.prdata = r.mask[63:32];
        `OFF_ADDR:     n.prdata = r.addr;
        `OFF_STAT:     n.prdata = {27'h0, r.done, busy, r.fault};
        `OFF_TBM_LO:   n.prdata = r.tbm[31:0];
        `OFF_TBM_HI:   n.prdata = r.tbm[63:32];
        `OFF_TADDR:    n.prdata = r.taddr;
        `OFF_TMISC:    n.prdata = {28'h0, r.tnr, 1'b0, r.tcpl};
        default:       n.prdata = 32'h0000_0000;
      endcase
    end
    if (wr && !busy) begin
      unique case (paddr)
        `OFF_UCE_LO: begin
          if (pwdata[2] && !pwdata[1])
            n.fault = F_XCW;
          else
            n.uce[31:0] = pwdata;
        end
        `OFF_UCE_HI:   n.uce[63:32] = pwdata;
        `OFF_SCE_LO:   n.sce[31:0] = pwdata;
        `OFF_SCE_HI:   n.sce[63:32] = pwdata;
        `OFF_CTRL:     n.ctrl = pwdata;
        `OFF_SIMD:     n.simd = pwdata;
        `OFF_INUSE_LO: n.inuse[31:0] = pwdata;
        `OFF_INUSE_HI: n.inuse[63:32] = pwdata;
        `OFF_MOD_LO:   n.modif[31:0] = pwdata;
        `OFF_MOD_HI:   n.modif[63:32] = pwdata;
        `OFF_MASK_LO:  n.mask[31:0] = pwdata;
        `OFF_MASK_HI:  n.mask[63:32] = pwdata;
        `OFF_ADDR:     n.addr = pwdata;
        `OFF_CMD: begin
          if (pwdata[`CMD_REC_SUP] || pwdata[`CMD_REC_STD]) begin
            n.tcpl = current_privilege_level;
            n.tnr = r.ctrl[`CTRL_NR];
            n.taddr = r.addr;
            n.tbm = {pwdata[`CMD_REC_SUP], requested_bitmap[62:0]};
          end
          if (pwdata[`CMD_SAVE]) begin
            n.done = 1'b0;
            n.fault = F_NONE;
            if (!r.ctrl[`CTRL_OSX])
              n.fault = F_BAD_OP;
            else if (r.ctrl[`CTRL_TS])
              n.fault = F_NO_DEV;
            else if (r.ctrl[`CTRL_AM] && r.ctrl[`CTRL_ACF] && mis &&
                     current_privilege_level == 2'h3)
              n.fault = F_ALIGN;
            else if (current_privilege_level != 2'h0 || mis)
              n.fault = F_PROT;
            else begin
              // writing starts only after a clean check
              n.st = S_HDRS;
              n.idx = 6'h00;
              n.ext = 6'h00;
              n.mem.req = 1'b1;
              n.mem.addr = r.addr + `HDR_STATE_OFF;
              n.mem.wdata = state_bitmap;
            end
          end
        end
        default: ;
      endcase
    end
    unique case (r.st)
      S_IDLE: ;
      S_HDRS: begin
        if (mem_ack) begin
          n.st = S_HDRC;
          n.mem.addr = r.addr + `HDR_COMP_OFF;
          n.mem.wdata = {1'b1, requested_bitmap[62:0]};
        end
      end
      S_HDRC: begin
        if (mem_ack) begin
          n.st = S_COMP;
          n.mem.req = 1'b0;
        end
      end
      S_COMP: begin
        if (!r.mem.req) begin
          if (store) begin
            n.mem.req = 1'b1;
            n.mem.addr = comp_addr(r.addr, r.idx, r.ext);
            n.mem.wdata = comp_data;
          end else
            adv = 1'b1;
        end else if (mem_ack) begin
          n.mem.req = 1'b0;
          adv = 1'b1;
        end
        if (adv) begin
          // Offsets follow the bitmap, even for skipped components
          if (r.idx >= 6'h02 && requested_bitmap[r.idx])
            n.ext = r.ext + 6'h01;
          if (r.idx == `LAST_COMP) begin
            n.st = S_IDLE;
            n.done = 1'b1;
          end else
            n.idx = r.idx + 6'h01;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.st <= S_IDLE;
      r.fault <= F_NONE;
      r.uce <= `RST_UCE;
      r.simd <= `RST_SIMD;
    end else begin
      r <= n;
    end
  end

  assign prdata   = r.prdata;
  assign pready   = r.pready;
  assign pslverr  = r.pslverr;
  assign mem_o    = r.mem;
  assign comp_sel = r.idx;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic go;
  assign go = wr && !busy && paddr == `OFF_CMD && pwdata[`CMD_SAVE];

  AST_BAD_OP: assert property (go && !r.ctrl[`CTRL_OSX] |=>
    r.fault == F_BAD_OP && !busy) else $error("missing invalid opcode");
  AST_NO_DEV: assert property (go && r.ctrl[`CTRL_OSX] &&
    r.ctrl[`CTRL_TS] |=> r.fault == F_NO_DEV && !busy)
    else $error("missing device fault");
  AST_PRIV: assert property (go && r.ctrl[`CTRL_OSX] &&
    !r.ctrl[`CTRL_TS] && current_privilege_level != 2'h0 |=>
    r.fault inside {F_PROT, F_ALIGN} && !busy)
    else $error("save allowed above level zero");
  AST_ALIGN: assert property (go && r.ctrl[`CTRL_OSX] &&
    !r.ctrl[`CTRL_TS] && mis && !r.ctrl[`CTRL_AM] |=> r.fault == F_PROT)
    else $error("misaligned save accepted");
  AST_ALIGN_CHK: assert property (go && r.ctrl[`CTRL_OSX] &&
    !r.ctrl[`CTRL_TS] && r.ctrl[`CTRL_AM] && r.ctrl[`CTRL_ACF] && mis &&
    current_privilege_level == 2'h3 |=> r.fault == F_ALIGN)
    else $error("alignment check not raised");
  AST_NOWRITE: assert property (go && (!r.ctrl[`CTRL_OSX] ||
    r.ctrl[`CTRL_TS] || current_privilege_level != 2'h0 || mis) |=>
    !mem_o.req [*2]) else $error("memory written on fault");
  AST_XSTATE: assert property (r.st == S_HDRS && mem_o.req |->
    (mem_o.wdata & ~requested_bitmap) == 64'h0 &&
    (!(requested_bitmap[1] && mxd) || mem_o.wdata[1]))
    else $error("bad state bitmap");
  AST_INUSE: assert property (r.st == S_HDRS && mem_o.req |->
    (requested_bitmap & r.inuse & ~mem_o.wdata) == 64'h0)
    else $error("in-use component marked initial");
  AST_XCOMP: assert property (r.st == S_HDRC && mem_o.req |->
    mem_o.wdata == {1'b1, requested_bitmap[62:0]})
    else $error("bad compaction bitmap");
  AST_SKIP: assert property (r.st == S_COMP && mem_o.req |->
    r.inuse[r.idx] || (r.idx == 6'h01 && mxd)) else $error("idle stored");
  AST_MOD: assert property (r.st == S_COMP && mem_o.req && modopt
    |-> r.modif[r.idx]) else $error("unmodified stored");
  AST_EXT: assert property (r.st == S_COMP && mem_o.req &&
    r.idx >= 6'h02 |-> mem_o.addr >= r.addr + `EXT_OFF)
    else $error("extended store below region");
  AST_XCW: assert property (wr && !busy && paddr == `OFF_UCE_LO &&
    pwdata[2] && !pwdata[1] |=> r.fault == F_XCW && $stable(r.uce))
    else $error("bad control write accepted");
  AST_TUPLE: assert property (wr && !busy && paddr == `OFF_CMD &&
    pwdata[`CMD_REC_SUP] |=> r.tbm[63] &&
    r.tcpl == $past(current_privilege_level))
    else $error("tuple not recorded");
endmodule
